// *** hw/power_state_controller.sv ***
// power state controller with power sequencer and axi4-lite registers
// Functional notes
// - no supply: hold global reset, all off
// - off: everything off except backup regulator
// - power-on needs no disable and one source
// - sources: button low, hold high, software bit
// - new unmasked irq pulses power-on while off
// - gpio 0,1,3,4,5 may wake; gpio 2 never
// - watchdog wakes from sleep, never powers on
// - long button press disables, sets status bit
// - thermal shutdown disables power-on
// - off bits disable; off bit self-clears in off
// - power-on bit still set restarts the device
// - sleep: pin level, sleep bit, nothing pending
// - power-on reset clears all logic
// - general reset keeps interrupt status
// - switch-on walks fifteen time slots
// - slot lasts 0.5 ms or 2 ms
// - unassigned resource stays off, setting writable
// - off all at once or reversed order
// - strap 0 fixed boot, 1 stored boot
// - strap pad disabled after sampling
// - converter boot setting has 16 steps
// - after thermal trip wait for cool die
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module power_state_controller #(
    parameter int TICK_CYC = psc_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // asynchronous system pins
    input wire logic push_button_in,
    input wire logic power_hold_in,
    input wire logic sleep_in,
    input wire logic hard_reset_in,
    input wire logic backup_supply_ok,
    input wire logic thermal_shutdown_flag,
    input wire logic hot_die_flag,
    input wire logic boot_strap_pin,
    input wire logic [5:0] gpio_irq_in,
    input wire logic watchdog_irq_in,
    input wire logic rtc_alarm_in,
    // stored boot table
    input wire logic [31:0] stored_boot_slots,
    input wire logic [11:0] stored_boot_volts,
    // power outputs
    output logic [7:0] resource_en,
    output logic [11:0] boot_volt_sel,
    output logic system_reset_out_n,
    output logic global_reset_out,
    output logic interrupt_flag_out_n,
    output logic boot_pad_en
);
    // whole state of the block
    typedef struct packed {
        logic [15:0] s1;        // first sync stage
        logic [15:0] s2;        // second sync stage
        logic [7:0] ev_prev;    // event levels last cycle
        psc_pkg::pstate_t st;
        logic [17:0] tick_cnt;  // half-millisecond prescaler
        logic tick;
        logic [3:0] slot;
        logic [2:0] sub;        // ticks spent in slot
        logic [7:0] lp_cnt;
        logic lp_hold;
        logic [7:0] pulse_cnt;
        logic therm_lock;
        logic [1:0] boot_cnt;
        logic boot_done;
        logic boot_mode;
        logic [9:0] ctrl;
        logic [9:0] irq_sts;
        logic [9:0] irq_msk;
        logic [7:0] lp_delay;
        logic [31:0] slots;
        logic [11:0] volts;
        logic [7:0] res_en;
        logic rst_out_n;
        logic glob_rst;
        logic irq_n;
        logic pad_en;
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic awrdy;
        logic wrdy;
        logic arrdy;
        logic b_v;
        logic [1:0] b_resp;
        logic r_v;
        logic [1:0] r_resp;
        logic [31:0] r_d;
    } state_t;

    localparam state_t Q_RST = '{default: '0,
        st: psc_pkg::ST_NO_SUPPLY, ctrl: psc_pkg::CTRL_RST,
        irq_msk: psc_pkg::MSK_RST, lp_delay: psc_pkg::LPD_RST,
        slots: psc_pkg::FIXED_SLOTS, volts: psc_pkg::FIXED_VOLTS,
        glob_rst: 1'b1, irq_n: 1'b1, pad_en: 1'b1};

    state_t q;                // registered state
    state_t n;                // next state
    logic [15:0] pins;        // raw pins in sync order
    logic [7:0] ev_now;       // event levels after sync
    logic [7:0] ev_rise;      // new events
    logic [9:0] sts_set;      // hardware sets of status
    logic [9:0] sts_clr;      // software write-one clears
    logic [31:0] wmask;       // byte lanes of a write
    logic [31:0] wval;        // write data merged into lanes
    logic do_wr;
    logic pon;                // power-on enabled
    logic dis;                // a disable condition holds
    logic src;                // a power-on source holds
    logic pend;               // unmasked interrupt pending
    logic slp_en;             // sleep conditions met
    logic lp_trip;            // long press just reached
    logic gen_rst;            // general reset request
    logic start_off;
    logic fire;               // slot boundary reached
    logic [2:0] spt;          // ticks per slot

    assign pins = {rtc_alarm_in, watchdog_irq_in, gpio_irq_in,
        boot_strap_pin, hot_die_flag, thermal_shutdown_flag,
        backup_supply_ok, hard_reset_in, sleep_in, power_hold_in,
        push_button_in};

    // next-state logic for bus, conditions and sequencer
    always_comb begin
        n = q;
        n.s1 = pins;
        n.s2 = q.s1;
        ev_now = {q.s2[psc_pkg::P_WDOG], q.s2[psc_pkg::P_RTC],
            q.s2[psc_pkg::P_GPIO +: 6]};
        n.ev_prev = ev_now;
        ev_rise = ev_now & ~q.ev_prev;
        // free-running tick, cheap and keeps slots aligned
        n.tick = (q.tick_cnt == 18'(TICK_CYC - 1));
        n.tick_cnt = n.tick ? 18'h0 : q.tick_cnt + 18'h1;
        // register writes, address and data in either order
        if (q.awrdy && awvalid) begin
            n.aw_v = 1'b1;
            n.aw_a = awaddr;
        end
        if (q.wrdy && wvalid) begin
            n.w_v = 1'b1;
            n.w_d = wdata;
            n.w_s = wstrb;
        end
        do_wr = q.aw_v && q.w_v && !q.b_v;
        wmask = {{8{q.w_s[3]}}, {8{q.w_s[2]}}, {8{q.w_s[1]}},
            {8{q.w_s[0]}}};
        wval = 32'h0;
        sts_clr = 10'h0;
        if (do_wr) begin
            n.aw_v = 1'b0;
            n.w_v = 1'b0;
            n.b_v = 1'b1;
            n.b_resp = psc_pkg::RESP_OKAY;
            unique case (q.aw_a)
                psc_pkg::A_CTRL: begin
                    wval = ({22'h0, q.ctrl} & ~wmask) | (q.w_d & wmask);
                    n.ctrl = wval[9:0];
                end
                psc_pkg::A_STS: begin
                    sts_clr = q.w_d[9:0] & wmask[9:0];
                end
                psc_pkg::A_MSK: begin
                    wval = ({22'h0, q.irq_msk} & ~wmask) | (q.w_d & wmask);
                    n.irq_msk = wval[9:0];
                end
                psc_pkg::A_LPD: begin
                    if (q.w_s[0]) n.lp_delay = q.w_d[7:0];
                end
                psc_pkg::A_SLOTS: begin
                    n.slots = (q.slots & ~wmask) | (q.w_d & wmask);
                end
                psc_pkg::A_VOLTS: begin
                    // settings stay writable in any state
                    wval = ({20'h0, q.volts} & ~wmask) | (q.w_d & wmask);
                    n.volts = wval[11:0];
                end
                psc_pkg::A_STATE: begin
                    n.b_resp = psc_pkg::RESP_OKAY; // read-only, ignored
                end
                default: begin
                    n.b_resp = psc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.b_v && bready) n.b_v = 1'b0;
        // register reads, answered one cycle after acceptance
        if (q.arrdy && arvalid) begin
            n.r_v = 1'b1;
            n.r_resp = psc_pkg::RESP_OKAY;
            unique case (araddr)
                psc_pkg::A_CTRL: n.r_d = {22'h0, q.ctrl};
                psc_pkg::A_STS: n.r_d = {22'h0, q.irq_sts};
                psc_pkg::A_MSK: n.r_d = {22'h0, q.irq_msk};
                psc_pkg::A_LPD: n.r_d = {24'h0, q.lp_delay};
                psc_pkg::A_SLOTS: n.r_d = q.slots;
                psc_pkg::A_VOLTS: n.r_d = {20'h0, q.volts};
                psc_pkg::A_STATE: n.r_d = {10'h0, q.pulse_cnt != 8'h0,
                    q.therm_lock, q.res_en, q.slot, q.boot_mode,
                    q.boot_done, q.lp_hold, 2'h0, q.st};
                default: begin
                    n.r_d = 32'h0;
                    n.r_resp = psc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.r_v && rready) n.r_v = 1'b0;
        // boot strap caught once the synchroniser has settled
        if (!q.boot_done) begin
            n.boot_cnt = q.boot_cnt + 2'h1;
            if (q.boot_cnt == psc_pkg::BOOT_WAIT) begin
                n.boot_done = 1'b1;
                n.boot_mode = q.s2[psc_pkg::P_BOOT];
                n.slots = q.s2[psc_pkg::P_BOOT] ? stored_boot_slots
                    : psc_pkg::FIXED_SLOTS;
                n.volts = q.s2[psc_pkg::P_BOOT] ? stored_boot_volts
                    : psc_pkg::FIXED_VOLTS;
            end
        end
        n.pad_en = !n.boot_done;
        // long press on the button
        lp_trip = 1'b0;
        if (!q.s2[psc_pkg::P_PB] && q.ctrl[psc_pkg::C_LP_EN]) begin
            if (q.tick && q.lp_cnt != q.lp_delay) n.lp_cnt = q.lp_cnt + 8'h1;
            lp_trip = (q.lp_cnt == q.lp_delay) && !q.lp_hold;
            if (lp_trip) n.lp_hold = 1'b1;
        end else begin
            n.lp_cnt = 8'h0;
            n.lp_hold = 1'b0;
        end
        // thermal lock until the die has cooled below hot-die
        if (q.s2[psc_pkg::P_TSD]) begin
            n.therm_lock = 1'b1;
        end else if (!q.s2[psc_pkg::P_HOT]) begin
            n.therm_lock = 1'b0;
        end
        // sticky status, a set in the clearing cycle wins
        sts_set = {q.s2[psc_pkg::P_TSD] && !q.therm_lock, lp_trip, ev_rise};
        n.irq_sts = (q.irq_sts & ~sts_clr) | sts_set;
        // wake pulse only for fresh, unmasked wake sources
        if (q.st == psc_pkg::ST_OFF && |(sts_set & ~q.irq_sts & ~q.irq_msk
            & psc_pkg::IRQ_WAKE_BITS)) begin
            n.pulse_cnt = psc_pkg::IRQ_PULSE_TICKS;
        end else if (q.tick && q.pulse_cnt != 8'h0) begin
            n.pulse_cnt = q.pulse_cnt - 8'h1;
        end
        // power-on and sleep conditions
        dis = q.lp_hold || q.therm_lock || q.ctrl[psc_pkg::C_OFF]
            || q.ctrl[psc_pkg::C_OFF_RST];
        src = !q.s2[psc_pkg::P_PB]
            || (q.s2[psc_pkg::P_HOLD] && !q.ctrl[psc_pkg::C_HOLD_GPI])
            || q.ctrl[psc_pkg::C_ON] || q.pulse_cnt != 8'h0;
        pon = !dis && src && q.boot_done;
        pend = |(q.irq_sts & ~q.irq_msk);
        slp_en = (q.s2[psc_pkg::P_SLEEP] == q.ctrl[psc_pkg::C_SLP_POL])
            && q.ctrl[psc_pkg::C_SLP] && !pend;
        spt = q.ctrl[psc_pkg::C_SLOT_LONG] ? psc_pkg::LONG_SLOT_TICKS
            : psc_pkg::SHORT_SLOT_TICKS;
        start_off = 1'b0;
        fire = 1'b0;
        gen_rst = q.s2[psc_pkg::P_HRST]
            || (lp_trip && q.ctrl[psc_pkg::C_LP_RST]);
        // power state machine
        unique case (q.st)
            psc_pkg::ST_NO_SUPPLY: begin
                if (q.s2[psc_pkg::P_BOK]) n.st = psc_pkg::ST_OFF;
            end
            psc_pkg::ST_OFF: begin
                n.res_en = 8'h0;
                if (pon) begin
                    n.st = psc_pkg::ST_SEQ_ON;
                    n.slot = psc_pkg::FIRST_SLOT;
                    n.sub = 3'h0;
                    fire = 1'b1;
                end
            end
            psc_pkg::ST_SEQ_ON: begin
                if (!pon) begin
                    start_off = 1'b1;
                end else if (q.tick) begin
                    if (q.sub == spt - 3'h1) begin
                        n.sub = 3'h0;
                        if (q.slot == psc_pkg::LAST_SLOT) begin
                            n.st = psc_pkg::ST_ACTIVE;
                        end else begin
                            n.slot = q.slot + 4'h1;
                            fire = 1'b1;
                        end
                    end else begin
                        n.sub = q.sub + 3'h1;
                    end
                end
            end
            psc_pkg::ST_ACTIVE: begin
                if (!pon) start_off = 1'b1;
                else if (slp_en) n.st = psc_pkg::ST_SLEEP;
            end
            psc_pkg::ST_SLEEP: begin
                if (!pon) start_off = 1'b1;
                else if (!slp_en || ev_rise[psc_pkg::I_WDOG])
                    n.st = psc_pkg::ST_ACTIVE;
            end
            psc_pkg::ST_SEQ_OFF: begin
                if (q.tick) begin
                    if (q.sub == spt - 3'h1) begin
                        n.sub = 3'h0;
                        if (q.slot == psc_pkg::FIRST_SLOT) begin
                            n.st = psc_pkg::ST_OFF;
                            n.res_en = 8'h0;
                        end else begin
                            n.slot = q.slot - 4'h1;
                            fire = 1'b1;
                        end
                    end else begin
                        n.sub = q.sub + 3'h1;
                    end
                end
            end
            default: n.st = psc_pkg::ST_OFF;
        endcase
        // switch-off: reversed walk or everything at once
        if (start_off) begin
            if (q.ctrl[psc_pkg::C_REV_OFF]) begin
                n.st = psc_pkg::ST_SEQ_OFF;
                n.slot = psc_pkg::LAST_SLOT;
                n.sub = 3'h0;
                fire = 1'b1;
            end else begin
                n.st = psc_pkg::ST_OFF;
                n.res_en = 8'h0;
            end
        end
        // resources whose slot number matches switch; slot 0 never
        if (fire) begin
            for (int i = 0; i < 8; i++) begin
                if (q.slots[4*i +: 4] == n.slot)
                    n.res_en[i] = (n.st == psc_pkg::ST_SEQ_ON);
            end
        end
        // arriving in off clears the off bit, or resets the controls
        if (n.st == psc_pkg::ST_OFF && q.st != psc_pkg::ST_OFF) begin
            n.ctrl[psc_pkg::C_OFF] = 1'b0;
            if (q.ctrl[psc_pkg::C_OFF_RST]) gen_rst = 1'b1;
        end
        // general reset keeps status, drops controls and power
        if (gen_rst) begin
            n.ctrl = psc_pkg::CTRL_RST;
            n.irq_msk = psc_pkg::MSK_RST;
            n.lp_delay = psc_pkg::LPD_RST;
            n.pulse_cnt = 8'h0;
            n.res_en = 8'h0;
            n.st = psc_pkg::ST_OFF;
        end
        // battery too low overrides everything
        if (!q.s2[psc_pkg::P_BOK]) begin
            n.st = psc_pkg::ST_NO_SUPPLY;
            n.res_en = 8'h0;
        end
        n.glob_rst = (n.st == psc_pkg::ST_NO_SUPPLY);
        n.rst_out_n = (n.st == psc_pkg::ST_ACTIVE)
            || (n.st == psc_pkg::ST_SLEEP);
        n.irq_n = !(|(n.irq_sts & ~n.irq_msk));
        n.awrdy = !n.aw_v && !n.b_v;
        n.wrdy = !n.w_v && !n.b_v;
        n.arrdy = !n.r_v;
    end

    // one register for the whole state; power-on reset clears all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= Q_RST;
        end else begin
            q <= n;
        end
    end

    // outputs straight from the state register
    assign awready = q.awrdy;
    assign wready = q.wrdy;
    assign bvalid = q.b_v;
    assign bresp = q.b_resp;
    assign arready = q.arrdy;
    assign rvalid = q.r_v;
    assign rresp = q.r_resp;
    assign rdata = q.r_d;
    assign resource_en = q.res_en;
    assign boot_volt_sel = q.volts;
    assign system_reset_out_n = q.rst_out_n;
    assign global_reset_out = q.glob_rst;
    assign interrupt_flag_out_n = q.irq_n;
    assign boot_pad_en = q.pad_en;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    nosupply_reset_a: assert property (
        q.st == psc_pkg::ST_NO_SUPPLY |-> global_reset_out
            && resource_en == 8'h0) else $error("no-supply not held");
    off_all_dark_a: assert property (
        q.st == psc_pkg::ST_OFF |-> resource_en == 8'h0)
        else $error("resource on while off");
    pon_start_a: assert property (
        q.st == psc_pkg::ST_OFF && pon && !gen_rst
            && q.s2[psc_pkg::P_BOK] |=> q.st == psc_pkg::ST_SEQ_ON)
        else $error("power-on not started");
    gpio2_nowake_a: assert property (
        q.st == psc_pkg::ST_OFF && q.pulse_cnt == 8'h0
            && ev_rise == 8'h04 |=> q.pulse_cnt == 8'h0)
        else $error("gpio 2 powered on");
    wdog_nowake_a: assert property (
        q.st == psc_pkg::ST_OFF && q.pulse_cnt == 8'h0
            && ev_rise == 8'h80 |=> q.pulse_cnt == 8'h0)
        else $error("watchdog powered on");
    long_press_a: assert property (
        lp_trip |=> q.irq_sts[psc_pkg::I_LP] && q.lp_hold)
        else $error("long press not flagged");
    thermal_block_a: assert property (
        q.therm_lock && q.st == psc_pkg::ST_OFF
            |=> q.st != psc_pkg::ST_SEQ_ON) else $error("thermal ignored");
    off_bit_clear_a: assert property (
        q.st != psc_pkg::ST_OFF ##1 q.st == psc_pkg::ST_OFF
            |-> !q.ctrl[psc_pkg::C_OFF]) else $error("off bit kept");
    sleep_entry_a: assert property (
        $rose(q.st == psc_pkg::ST_SLEEP) |-> $past(q.ctrl[psc_pkg::C_SLP])
            && !$past(pend)) else $error("bad sleep entry");
    slot_step_a: assert property (
        q.st == psc_pkg::ST_SEQ_ON && q.tick && q.sub == spt - 3'h1
            && q.slot != psc_pkg::LAST_SLOT && pon && !gen_rst
            && q.s2[psc_pkg::P_BOK] |=> q.slot == $past(q.slot) + 4'h1)
        else $error("slot did not advance");
    active_cov: cover property ($rose(q.st == psc_pkg::ST_ACTIVE));
    sleep_cov: cover property ($rose(q.st == psc_pkg::ST_SLEEP));
    rev_off_cov: cover property ($rose(q.st == psc_pkg::ST_SEQ_OFF));
endmodule
`default_nettype wire

// *** hw/psc_pkg.sv ***
// constants shared by the power state controller
package psc_pkg;
    // clock and slot timing
    localparam int CLK_MHZ = 125;
    localparam int SLOT_SHORT_US = 500;
    localparam int SLOT_LONG_US = 2000;
    localparam int TICK_CYC = SLOT_SHORT_US * CLK_MHZ;
    localparam logic [2:0] SHORT_SLOT_TICKS = 3'h1;
    localparam logic [2:0] LONG_SLOT_TICKS = 3'(SLOT_LONG_US / SLOT_SHORT_US);
    localparam logic [3:0] FIRST_SLOT = 4'h1;
    localparam logic [3:0] LAST_SLOT = 4'hf;
    localparam logic [7:0] IRQ_PULSE_TICKS = 8'h08;
    localparam logic [1:0] BOOT_WAIT = 2'h3;
    // synchronised pin positions
    localparam int P_PB = 0;
    localparam int P_HOLD = 1;
    localparam int P_SLEEP = 2;
    localparam int P_HRST = 3;
    localparam int P_BOK = 4;
    localparam int P_TSD = 5;
    localparam int P_HOT = 6;
    localparam int P_BOOT = 7;
    localparam int P_GPIO = 8;
    localparam int P_WDOG = 14;
    localparam int P_RTC = 15;
    // control register bits
    localparam int C_ON = 0;
    localparam int C_OFF = 1;
    localparam int C_OFF_RST = 2;
    localparam int C_SLP = 3;
    localparam int C_REV_OFF = 4;
    localparam int C_SLOT_LONG = 5;
    localparam int C_LP_EN = 6;
    localparam int C_LP_RST = 7;
    localparam int C_HOLD_GPI = 8;
    localparam int C_SLP_POL = 9;
    localparam logic [9:0] CTRL_RST = 10'h040;
    // interrupt status bits: gpio 0..5 then these
    localparam int I_RTC = 6;
    localparam int I_WDOG = 7;
    localparam int I_LP = 8;
    localparam int I_TSD = 9;
    localparam logic [9:0] IRQ_WAKE_BITS = 10'h07b;
    localparam logic [9:0] MSK_RST = 10'h000;
    localparam logic [7:0] LPD_RST = 8'h10;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STS = 8'h04;
    localparam logic [7:0] A_MSK = 8'h08;
    localparam logic [7:0] A_LPD = 8'h0c;
    localparam logic [7:0] A_SLOTS = 8'h10;
    localparam logic [7:0] A_VOLTS = 8'h14;
    localparam logic [7:0] A_STATE = 8'h18;
    // fixed boot table: 4-bit slot per resource, 4-bit step per converter
    localparam logic [31:0] FIXED_SLOTS = 32'h5601_5063;
    localparam logic [11:0] FIXED_VOLTS = 12'h0fa;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // controller states
    typedef enum logic [2:0] {
        ST_NO_SUPPLY, ST_OFF, ST_SEQ_ON, ST_ACTIVE, ST_SLEEP, ST_SEQ_OFF
    } pstate_t;
endpackage

// *** verification/sys_pins_model.sv ***
// system pin model facing the power state controller
`timescale 1ns/100ps
`default_nettype none
module sys_pins_model (
    // clock for event pulses
    input wire logic clk,
    // level pins, idle: button up, supply good, cool die
    output var logic push_button_in = 1'b1,
    output var logic power_hold_in = 1'b0,
    output var logic sleep_in = 1'b1,
    output var logic hard_reset_in = 1'b0,
    output var logic backup_supply_ok = 1'b1,
    output var logic thermal_shutdown_flag = 1'b0,
    output var logic hot_die_flag = 1'b0,
    output var logic boot_strap_pin = 1'b0,
    // events: gpio 0..5, watchdog, alarm
    output var logic [7:0] events = 8'h00
);
    // pulse held past the two-flop synchroniser
    task automatic pulse(input int n);
        @(posedge clk);
        events[n] <= 1'b1;
        repeat (4) @(posedge clk);
        events[n] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verification/test_power_state_controller.sv ***
// self-checking bench for the power state controller
`timescale 1ns/100ps
`default_nettype none
module test_power_state_controller;
    // bus master side
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_q;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp_q;
    logic [3:0] wstrb = 4'hf;
    // stored boot table, picked only with the strap high
    logic [31:0] boot_slots = 32'h1234_5678;
    logic [11:0] boot_volts = 12'h9a5;
    // power outputs and pins
    logic [7:0] resource_en, exp_en, events;
    logic [11:0] boot_volt_sel;
    logic system_reset_out_n, global_reset_out, interrupt_flag_out_n;
    logic boot_pad_en, push_button_in, power_hold_in, sleep_in;
    logic hard_reset_in, backup_supply_ok, thermal_shutdown_flag;
    logic hot_die_flag, boot_strap_pin;
    int n_mismatch = 0;
    int check_count = 0;

    // 125 MHz
    always #4 aclk = ~aclk;

    sys_pins_model u_pins (.clk(aclk), .push_button_in, .power_hold_in,
        .sleep_in, .hard_reset_in, .backup_supply_ok,
        .thermal_shutdown_flag, .hot_die_flag, .boot_strap_pin, .events);

    // tiny tick keeps each slot at four clocks
    power_state_controller #(.TICK_CYC(4)) u_dut (.aclk, .aresetn,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .push_button_in, .power_hold_in,
        .sleep_in, .hard_reset_in, .backup_supply_ok,
        .thermal_shutdown_flag, .hot_die_flag, .boot_strap_pin,
        .gpio_irq_in(events[5:0]), .watchdog_irq_in(events[6]),
        .rtc_alarm_in(events[7]), .stored_boot_slots(boot_slots),
        .stored_boot_volts(boot_volts), .resource_en, .boot_volt_sel,
        .system_reset_out_n, .global_reset_out, .interrupt_flag_out_n,
        .boot_pad_en);

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one transfer; each channel dropped at its own handshake
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                resp_q = bresp;
            end
            if (rvalid && rready) begin
                rready <= 1'b0;
                rd_q = rdata;
                resp_q = rresp;
            end
        end while ((bready || rready) && n < 100);
        if (n >= 100) begin
            n_mismatch++;
            end_sim;
        end
    endtask

    // poll the state field, bounded
    task automatic wait_state(input logic [2:0] s);
        for (int k = 0; k < 80; k++) begin
            xfer(1'b0, psc_pkg::A_STATE, 32'h0);
            if (rd_q[2:0] === s) break;
        end
        check("state", rd_q[2:0], s);
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        check("global reset", global_reset_out, 1'b1);
        check("sys reset", system_reset_out_n, 1'b0);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        check("boot pad", boot_pad_en, 1'b0);
        wait_state(3'h1);
        check("enables", resource_en, 8'h00);
        xfer(1'b0, 8'h1c, 32'h0);
        check("resp", resp_q, psc_pkg::RESP_SLVERR);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
            exp_en[i] = psc_pkg::FIXED_SLOTS[4*i +: 4] != 4'h0;
        xfer(1'b1, psc_pkg::A_CTRL, 32'h041);
        wait_state(3'h3);
        check("enables", resource_en, exp_en);
        check("volts", boot_volt_sel, psc_pkg::FIXED_VOLTS);
        check("sys reset", system_reset_out_n, 1'b1);
        // sleep bit set once, then the pin decides
        xfer(1'b1, psc_pkg::A_CTRL, 32'h049);
        @(posedge aclk) u_pins.sleep_in <= 1'b0;
        wait_state(3'h4);
        u_pins.pulse(6);
        wait_state(3'h3);
        check("irq out", interrupt_flag_out_n, 1'b0);
        @(posedge aclk) u_pins.sleep_in <= 1'b1;
        xfer(1'b1, psc_pkg::A_STS, 32'h3ff);
        $display("test sleep done");
        xfer(1'b1, psc_pkg::A_CTRL, 32'h042);
        wait_state(3'h1);
        check("enables", resource_en, 8'h00);
        xfer(1'b0, psc_pkg::A_CTRL, 32'h0);
        check("ctrl", rd_q, 32'h040);
        u_pins.pulse(2);
        repeat (20) @(posedge aclk);
        wait_state(3'h1);
        xfer(1'b1, psc_pkg::A_STS, 32'h3ff);
        u_pins.pulse(0);
        wait_state(3'h2);
        @(posedge aclk) u_pins.thermal_shutdown_flag <= 1'b1;
        wait_state(3'h1);
        // thermal shutdown flag, still high, keeps the device off despite the power-on bit
        xfer(1'b1, psc_pkg::A_CTRL, 32'h041);
        repeat (20) @(posedge aclk);
        wait_state(3'h1);
        $display("test power off done");
        // long press while held off
        u_pins.push_button_in <= 1'b0;
        repeat (90) @(posedge aclk);
        xfer(1'b0, psc_pkg::A_STS, 32'h0);
        check("long press", rd_q[psc_pkg::I_LP], 1'b1);
        u_pins.push_button_in <= 1'b1;
        // only the second byte lane of the mask takes the write
        wstrb <= 4'h2;
        xfer(1'b1, psc_pkg::A_MSK, 32'h3ff);
        wstrb <= 4'hf;
        xfer(1'b0, psc_pkg::A_MSK, 32'h0);
        check("mask lanes", rd_q, 32'h300);
        $display("test long press done");
        // second reset with the strap high takes the stored table
        aresetn <= 1'b0;
        u_pins.boot_strap_pin <= 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        check("stored volts", boot_volt_sel, boot_volts);
        xfer(1'b0, psc_pkg::A_SLOTS, 32'h0);
        check("stored slots", rd_q, boot_slots);
        $display("test stored boot done");
        end_sim;
    end
endmodule
`default_nettype wire
